/* src/fcc_codec.sv */
// Purpose: Build and check the frame control field of a frame header.
// Assumes: Frame inputs synchronous to CLK; one frame event per cycle.
// Notes:   Sequence state (first/last sequence) tracked per single exchange.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module fcc_codec
    import fcc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Transmit request: one frame header per pulse
    input  wire logic        TX_REQ,
    input  wire logic        TX_IS_DATA,
    input  wire logic        TX_IS_ACK,
    input  wire logic        TX_END_SEQ,
    input  wire logic        TX_NEW_EXCH,
    input  wire logic        TX_NEW_SEQ,
    input  wire logic        TX_XFER_INIT,
    input  wire logic        TX_LAST_EARLY,
    input  wire logic        TX_LC_LAST,
    input  wire logic [1:0]  TX_ABT_CODE,
    input  wire logic [1:0]  TX_FILL,
    output logic [23:0]      TX_FCTL,
    output logic             TX_VALID,
    // Receive header word 2
    input  wire logic        RX_VALID,
    input  wire logic [31:0] RX_WORD2,
    input  wire logic        RX_IS_DATA,
    input  wire logic        RX_IS_ACK,
    input  wire logic        RX_IS_BUSY,
    input  wire logic        RX_FIRST_OF_EXCH,
    output logic             RX_FV,
    output logic             RX_RESPONDER,
    output logic             RX_SRC_RECIP,
    output logic             RX_FIRST_SEQ,
    output logic             RX_LAST_SEQ,
    output logic             RX_END_SEQ,
    output logic             RX_PRIO_SEL,
    output logic             RX_INIT_XFER,
    output logic [1:0]       RX_ACK_FORM,
    output logic [1:0]       RX_ABT_CODE,
    output logic             RX_ABT_VALID,
    output logic             RX_REL_OFF,
    output logic [1:0]       RX_FILL,
    output logic             RX_BUSY_DATA,
    output logic             RX_BUSY_ACK,
    output logic             RJT_REQ,
    output logic [7:0]       RJT_REASON
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic        awh_q, awh_d, wh_q, wh_d;
    logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [9:0]  ctl_q, ctl_d;
    logic [23:0] rxf_q, rxf_d;
    logic [7:0]  rjc_q, rjc_d;

    // Transmit sequence state
    logic        first_q, first_d, lastst_q, lastst_d;
    logic [23:0] txf_q, txf_d;
    logic        txv_q, txv_d;

    // Receive output state
    logic        fv_q, fv_d, rsp_q, rsp_d, src_q, src_d, fs_q, fs_d, ls_q, ls_d;
    logic        es_q, es_d, pr_q, pr_d, si_q, si_d, av_q, av_d, ro_q, ro_d;
    logic        bd_q, bd_d, ba_q, ba_d, rj_q, rj_d;
    logic [1:0]  af_q, af_d, ab_q, ab_d, fl_q, fl_d;
    logic [7:0]  rr_q, rr_d;

    // Strobe-merge one byte lane group into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite next state; address and data taken in either order
    // Unstrobed lanes take the live control bits, so the commit is a plain copy
    always_comb begin
        awr_d = awr_q; wr_d = wr_q; bv_d = bv_q; arr_d = arr_q; rv_d = rv_q;
        awa_d = awa_q; awh_d = awh_q; wh_d = wh_q;
        wdat_d = wdat_q; rdat_d = rdat_q; bresp_d = bresp_q; rresp_d = rresp_q;
        ctl_d = ctl_q;
        awr_d = !awh_q && !bv_q;
        wr_d  = !wh_q && !bv_q;
        if (S_AXI_AWVALID && awr_q) begin
            awh_d = 1'b1;
            awa_d = S_AXI_AWADDR;
            awr_d = 1'b0;
        end
        if (S_AXI_WVALID && wr_q) begin
            wh_d   = 1'b1;
            // Safe: control cannot change again before this write commits
            wdat_d = merge({22'h000000, ctl_q}, S_AXI_WDATA, S_AXI_WSTRB);
            wr_d   = 1'b0;
        end
        // Both halves held: commit and answer
        if (awh_q && wh_q && !bv_q) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            // Only the control word is writable; read-only offsets still answer OKAY
            if (awa_q[7:2] == REG_TXCTL[7:2]) begin
                ctl_d   = wdat_q[9:0];
                bresp_d = RESP_OKAY;
            end else if (awa_q[7:2] == REG_TXFLD[7:2] || awa_q[7:2] == REG_RXFLD[7:2]
                         || awa_q[7:2] == REG_RXSTAT[7:2]) begin
                bresp_d = RESP_OKAY;
            end else begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (bv_q && S_AXI_BREADY) begin
            bv_d = 1'b0;
        end
        arr_d = !rv_q;
        if (S_AXI_ARVALID && arr_q) begin
            arr_d   = 1'b0;
            rv_d    = 1'b1;
            rresp_d = RESP_OKAY;
            if (S_AXI_ARADDR[7:2] == REG_TXCTL[7:2]) begin
                rdat_d = {22'h000000, ctl_q};
            end else if (S_AXI_ARADDR[7:2] == REG_TXFLD[7:2]) begin
                rdat_d = {8'h00, txf_q};
            end else if (S_AXI_ARADDR[7:2] == REG_RXFLD[7:2]) begin
                rdat_d = {8'h00, rxf_q};
            end else if (S_AXI_ARADDR[7:2] == REG_RXSTAT[7:2]) begin
                rdat_d = {24'h000000, rjc_q};
            end else begin
                rdat_d  = 32'h00000000;
                rresp_d = RESP_SLVERR;
            end
        end
        if (rv_q && S_AXI_RREADY) begin
            rv_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit builder
    logic [23:0] f;
    logic        lseq;
    always_comb begin
        first_d  = first_q;
        lastst_d = lastst_q;
        txv_d    = TX_REQ;
        txf_d    = txf_q;
        f        = 24'h000000;
        lseq     = 1'b0;
        if (TX_REQ) begin
            f[B_XCTX] = ctl_q[C_XRESP];
            f[B_SCTX] = ctl_q[C_SRCP];
            // First sequence flag clears once the exchange moves on
            f[B_FSEQ] = TX_NEW_EXCH || (first_q && !TX_NEW_SEQ);
            if (TX_IS_DATA) begin
                // Sticky once raised within the last sequence
                lseq = ctl_q[C_LASTX] && (TX_LAST_EARLY || TX_END_SEQ
                        || (lastst_q && !TX_NEW_SEQ && !TX_NEW_EXCH));
                f[B_ESEQ] = TX_END_SEQ;
                // Initiative transfer only on final frame
                f[B_SINIT] = TX_XFER_INIT && TX_END_SEQ;
                f[B_ACKH]  = ctl_q[C_ACKL+1] && ctl_q[C_CLS2];
                f[B_ACKL]  = (ctl_q[C_ACKL+1] || ctl_q[C_ACKL]) && ctl_q[C_CLS2];
                if (TX_NEW_EXCH) begin
                    f[B_ABTH:B_ABTL] = (ctl_q[C_ABTL+:2] == ABT_OBS) ? 2'h0
                                       : ctl_q[C_ABTL+:2];
                end
                f[B_RELOFF] = ctl_q[C_RELO];
                f[B_FILLH:B_FILLL] = TX_FILL;
                lastst_d = lseq && !TX_END_SEQ;
            end else begin
                // Link control echoes answered frame's bit
                lseq = TX_LC_LAST;
                f[B_ESEQ] = TX_END_SEQ && TX_IS_ACK;
                if (TX_IS_ACK) begin
                    f[B_ABTH:B_ABTL] = (TX_ABT_CODE == ABT_OBS) ? 2'h0 : TX_ABT_CODE;
                    f[B_SINIT] = TX_XFER_INIT && TX_END_SEQ;
                end
            end
            f[B_LSEQ] = lseq;
            f[B_PRIO] = ctl_q[C_PRIO];
            f = f & ~OBS_MASK & ~RSV_MASK;
            txf_d   = f;
            first_d = f[B_FSEQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive decoder: fields qualified by the conditions that give them meaning
    logic [23:0] g;
    logic        c2, bad;
    logic [7:0]  why;
    always_comb begin
        g   = RX_WORD2[23:0];
        c2  = ctl_q[C_CLS2];
        bad = 1'b0;
        why = 8'h00;
        fv_d = RX_VALID;
        rsp_d = g[B_XCTX];
        src_d = g[B_SCTX];
        fs_d  = g[B_FSEQ];
        ls_d  = g[B_LSEQ];
        es_d  = g[B_ESEQ] && (RX_IS_DATA || RX_IS_ACK);
        pr_d  = g[B_PRIO];
        si_d  = g[B_SINIT] && g[B_ESEQ];
        af_d  = (RX_IS_DATA && c2) ? g[B_ACKH:B_ACKL] : ACK_NONE;
        // Abort bits count only on ACKs or an exchange's first data frame
        av_d  = RX_IS_ACK || (RX_IS_DATA && RX_FIRST_OF_EXCH);
        ab_d  = av_d ? g[B_ABTH:B_ABTL] : 2'h0;
        ro_d  = g[B_RELOFF];
        fl_d  = RX_IS_DATA ? g[B_FILLH:B_FILLL] : 2'h0;
        // Busy answers our data frame if we initiated, our ACK if recipient
        bd_d  = RX_VALID && RX_IS_BUSY && c2 && !g[B_SCTX];
        ba_d  = RX_VALID && RX_IS_BUSY && c2 && g[B_SCTX];
        if (RX_IS_DATA && g[B_ACKH:B_ACKL] == ACK_RSV) begin
            bad = 1'b1;
            why = RJT_ACKFORM;
        end else if (av_d && g[B_ABTH:B_ABTL] == ABT_OBS) begin
            bad = 1'b1;
            why = RJT_ABTOBS;
        end else if (RX_IS_DATA && RX_FIRST_OF_EXCH && g[B_ABTH:B_ABTL] == POL_INF) begin
            bad = 1'b1;
            why = RJT_INFPOL;                  // Infinite buffers not allowed in Class 2
        end else if ((g & OBS_MASK) != 24'h000000) begin
            bad = 1'b1;
            why = RJT_OBSBIT;
        end
        rj_d  = RX_VALID && c2 && bad;
        rr_d  = (RX_VALID && c2 && bad) ? why : 8'h00;
        rxf_d = RX_VALID ? g : rxf_q;
        rjc_d = (RX_VALID && c2 && bad) ? why : rjc_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            awr_q <= 1'b0; wr_q <= 1'b0; bv_q <= 1'b0; arr_q <= 1'b0; rv_q <= 1'b0;
            awa_q <= 8'h00; awh_q <= 1'b0; wh_q <= 1'b0;
            wdat_q <= 32'h00000000; rdat_q <= 32'h00000000;
            bresp_q <= 2'h0; rresp_q <= 2'h0; ctl_q <= 10'h000;
            rxf_q <= 24'h000000; rjc_q <= 8'h00;
            first_q <= 1'b0; lastst_q <= 1'b0; txf_q <= 24'h000000; txv_q <= 1'b0;
            fv_q <= 1'b0; rsp_q <= 1'b0; src_q <= 1'b0; fs_q <= 1'b0; ls_q <= 1'b0;
            es_q <= 1'b0; pr_q <= 1'b0; si_q <= 1'b0; av_q <= 1'b0; ro_q <= 1'b0;
            bd_q <= 1'b0; ba_q <= 1'b0; rj_q <= 1'b0;
            af_q <= 2'h0; ab_q <= 2'h0; fl_q <= 2'h0; rr_q <= 8'h00;
        end else begin
            awr_q <= awr_d; wr_q <= wr_d; bv_q <= bv_d; arr_q <= arr_d; rv_q <= rv_d;
            awa_q <= awa_d; awh_q <= awh_d; wh_q <= wh_d;
            wdat_q <= wdat_d; rdat_q <= rdat_d;
            bresp_q <= bresp_d; rresp_q <= rresp_d; ctl_q <= ctl_d;
            rxf_q <= rxf_d; rjc_q <= rjc_d;
            first_q <= first_d; lastst_q <= lastst_d; txf_q <= txf_d; txv_q <= txv_d;
            fv_q <= fv_d; rsp_q <= rsp_d; src_q <= src_d; fs_q <= fs_d; ls_q <= ls_d;
            es_q <= es_d; pr_q <= pr_d; si_q <= si_d; av_q <= av_d; ro_q <= ro_d;
            bd_q <= bd_d; ba_q <= ba_d; rj_q <= rj_d;
            af_q <= af_d; ab_q <= ab_d; fl_q <= fl_d; rr_q <= rr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign S_AXI_AWREADY = awr_q;
    assign S_AXI_WREADY  = wr_q;
    assign S_AXI_BVALID  = bv_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_ARREADY = arr_q;
    assign S_AXI_RVALID  = rv_q;
    assign S_AXI_RDATA   = rdat_q;
    assign S_AXI_RRESP   = rresp_q;
    assign TX_FCTL       = txf_q;
    assign TX_VALID      = txv_q;
    assign RX_FV         = fv_q;
    assign RX_RESPONDER  = rsp_q;
    assign RX_SRC_RECIP  = src_q;
    assign RX_FIRST_SEQ  = fs_q;
    assign RX_LAST_SEQ   = ls_q;
    assign RX_END_SEQ    = es_q;
    assign RX_PRIO_SEL   = pr_q;
    assign RX_INIT_XFER  = si_q;
    assign RX_ACK_FORM   = af_q;
    assign RX_ABT_CODE   = ab_q;
    assign RX_ABT_VALID  = av_q;
    assign RX_REL_OFF    = ro_q;
    assign RX_FILL       = fl_q;
    assign RX_BUSY_DATA  = bd_q;
    assign RX_BUSY_ACK   = ba_q;
    assign RJT_REQ       = rj_q;
    assign RJT_REASON    = rr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_OBS_ZERO: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_VALID |-> (TX_FCTL & OBS_MASK) == 24'h000000)
        else $error("obsolete bit sent");
    AST_ACK_RSV: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_VALID |-> TX_FCTL[B_ACKH:B_ACKL] != ACK_RSV)
        else $error("reserved ack form sent");
    AST_SINIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_VALID && TX_FCTL[B_SINIT] |-> TX_FCTL[B_ESEQ])
        else $error("initiative without end of sequence");
    AST_XCTX: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_REQ |=> TX_FCTL[B_XCTX] == $past(ctl_q[C_XRESP]))
        else $error("exchange context wrong");
    AST_ESEQ: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_REQ && TX_IS_DATA |=> TX_FCTL[B_ESEQ] == $past(TX_END_SEQ))
        else $error("end of sequence wrong");
    AST_LC_LAST: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_REQ && !TX_IS_DATA |=> TX_FCTL[B_LSEQ] == $past(TX_LC_LAST))
        else $error("link control last bit not copied");
    AST_REJECT: assert property (@(posedge CLK) disable iff (SYS_RST)
        RX_VALID && ctl_q[C_CLS2] && RX_IS_DATA && RX_WORD2[13:12] == ACK_RSV
        |=> RJT_REQ && RJT_REASON == RJT_ACKFORM)
        else $error("reject not raised");
    AST_BUSY: assert property (@(posedge CLK) disable iff (SYS_RST)
        !(RX_BUSY_DATA && RX_BUSY_ACK))
        else $error("busy routed both ways");
    AST_RX_FV: assert property (@(posedge CLK) disable iff (SYS_RST)
        RX_VALID |=> RX_FV && RX_FILL == ($past(RX_IS_DATA) ? $past(RX_WORD2[1:0]) : 2'h0))
        else $error("fill bytes not presented");

endmodule : fcc_codec

/* src/fcc_pkg.sv */
// Purpose: Constants for the frame control field codec.
// Assumes: 24-bit control field in header word 2, bits 23..0.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
package fcc_pkg;
    // Field positions within the 24-bit control field
    localparam int B_XCTX   = 23;
    localparam int B_SCTX   = 22;
    localparam int B_FSEQ   = 21;
    localparam int B_LSEQ   = 20;
    localparam int B_ESEQ   = 19;
    localparam int B_PRIO   = 17;
    localparam int B_SINIT  = 16;
    localparam int B_ACKH   = 13;
    localparam int B_ACKL   = 12;
    localparam int B_ABTH   = 5;
    localparam int B_ABTL   = 4;
    localparam int B_RELOFF = 3;
    localparam int B_REASM  = 2;
    localparam int B_FILLH  = 1;
    localparam int B_FILLL  = 0;
    // Bits that must be sent as zero (obsolete 9, 8, 7-6)
    localparam logic [23:0] OBS_MASK = 24'h0003C0;
    // Reserved bits 18, 15, 14, 11, 10, 2
    localparam logic [23:0] RSV_MASK = 24'h04CC04;
    // Codes
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_RSV  = 2'h2;
    localparam logic [1:0] ABT_OBS  = 2'h3;
    localparam logic [1:0] POL_INF  = 2'h2;
    // Reject reason codes (values arbitrary-local)
    localparam logic [7:0] RJT_ACKFORM = 8'h01;
    localparam logic [7:0] RJT_ABTOBS  = 8'h02;
    localparam logic [7:0] RJT_INFPOL  = 8'h03;
    localparam logic [7:0] RJT_OBSBIT  = 8'h04;
    // Register byte offsets
    localparam logic [7:0] REG_TXCTL  = 8'h00;
    localparam logic [7:0] REG_TXFLD  = 8'h04;
    localparam logic [7:0] REG_RXFLD  = 8'h08;
    localparam logic [7:0] REG_RXSTAT = 8'h0C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // TXCTL field positions
    localparam int C_XRESP = 0;
    localparam int C_SRCP  = 1;
    localparam int C_PRIO  = 2;
    localparam int C_ACKL  = 3;
    localparam int C_ABTL  = 5;
    localparam int C_RELO  = 7;
    localparam int C_CLS2  = 8;
    localparam int C_LASTX = 9;
endpackage : fcc_pkg

/* sim/fcc_peer.sv */
// Purpose: Remote port model that sends header word 2 to the codec.
// Assumes: One header per call, driven just after a rising edge.
// Notes:   Idle word lines show the inverse of the last word sent.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fcc_peer (
    input  wire logic        CLK,
    output logic             RX_VALID,
    output logic [31:0]      RX_WORD2,
    output logic             RX_IS_DATA,
    output logic             RX_IS_ACK,
    output logic             RX_IS_BUSY,
    output logic             RX_FIRST_OF_EXCH
);
    // Quiet link at time zero
    initial begin
        {RX_VALID, RX_WORD2, RX_IS_DATA, RX_IS_ACK, RX_IS_BUSY, RX_FIRST_OF_EXCH} = '0;
    end

    // Header held for exactly one accepting edge
    task automatic send(input logic [31:0] w, input logic [3:0] q);
        @(posedge CLK);
        RX_VALID <= 1'b1;
        RX_WORD2 <= w; // Field in bits 23..0, bit 2 left clear
        {RX_IS_DATA, RX_IS_ACK, RX_IS_BUSY, RX_FIRST_OF_EXCH} <= q;
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_WORD2 <= ~w; // Stale word must not look valid
    endtask : send
endmodule : fcc_peer

/* sim/frame_control_field_codec_tb.sv */
// Purpose: Self-checking bench for the control field codec.
// Assumes: Register bus and frame ports driven by NBA after rising edges.
// Notes:   Fields whose meaning the rules leave open are not compared.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module frame_control_field_codec_tb
    import fcc_pkg::*;
;
    logic        CLK = 1'b0, SYS_RST = 1'b1;
    logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, RX_WORD2, d;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r, TX_ABT_CODE = '0, TX_FILL = '0;
    logic        TX_REQ = 0, TX_IS_DATA = 0, TX_IS_ACK = 0, TX_END_SEQ = 0, TX_NEW_EXCH = 0;
    logic        TX_NEW_SEQ = 0, TX_XFER_INIT = 0, TX_LAST_EARLY = 0, TX_LC_LAST = 0;
    logic [23:0] TX_FCTL;
    logic        TX_VALID, RX_VALID, RX_IS_DATA, RX_IS_ACK, RX_IS_BUSY, RX_FIRST_OF_EXCH;
    logic        RX_FV, RX_RESPONDER, RX_SRC_RECIP, RX_FIRST_SEQ, RX_LAST_SEQ, RX_END_SEQ;
    logic        RX_PRIO_SEL, RX_INIT_XFER, RX_ABT_VALID, RX_REL_OFF, RX_BUSY_DATA;
    logic        RX_BUSY_ACK, RJT_REQ;
    logic [1:0]  RX_ACK_FORM, RX_ABT_CODE, RX_FILL;
    logic [7:0]  RJT_REASON;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    logic [31:0] rjw [4] = '{32'h002000, 32'h000100, 32'h000020, 32'h400030};
    logic [3:0]  rjq [4] = '{4'h8, 4'h8, 4'h9, 4'h4};
    logic [7:0]  rjr [4] = '{RJT_ACKFORM, RJT_OBSBIT, RJT_INFPOL, RJT_ABTOBS};

    fcc_codec dut (
        .CLK(CLK), .SYS_RST(SYS_RST),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY),
        .TX_REQ(TX_REQ), .TX_IS_DATA(TX_IS_DATA), .TX_IS_ACK(TX_IS_ACK),
        .TX_END_SEQ(TX_END_SEQ), .TX_NEW_EXCH(TX_NEW_EXCH), .TX_NEW_SEQ(TX_NEW_SEQ),
        .TX_XFER_INIT(TX_XFER_INIT), .TX_LAST_EARLY(TX_LAST_EARLY),
        .TX_LC_LAST(TX_LC_LAST), .TX_ABT_CODE(TX_ABT_CODE), .TX_FILL(TX_FILL),
        .TX_FCTL(TX_FCTL), .TX_VALID(TX_VALID),
        .RX_VALID(RX_VALID), .RX_WORD2(RX_WORD2), .RX_IS_DATA(RX_IS_DATA),
        .RX_IS_ACK(RX_IS_ACK), .RX_IS_BUSY(RX_IS_BUSY),
        .RX_FIRST_OF_EXCH(RX_FIRST_OF_EXCH), .RX_FV(RX_FV),
        .RX_RESPONDER(RX_RESPONDER), .RX_SRC_RECIP(RX_SRC_RECIP),
        .RX_FIRST_SEQ(RX_FIRST_SEQ), .RX_LAST_SEQ(RX_LAST_SEQ),
        .RX_END_SEQ(RX_END_SEQ), .RX_PRIO_SEL(RX_PRIO_SEL),
        .RX_INIT_XFER(RX_INIT_XFER), .RX_ACK_FORM(RX_ACK_FORM),
        .RX_ABT_CODE(RX_ABT_CODE), .RX_ABT_VALID(RX_ABT_VALID),
        .RX_REL_OFF(RX_REL_OFF), .RX_FILL(RX_FILL),
        .RX_BUSY_DATA(RX_BUSY_DATA), .RX_BUSY_ACK(RX_BUSY_ACK),
        .RJT_REQ(RJT_REQ), .RJT_REASON(RJT_REASON)
    );
    fcc_peer  peer (
        .CLK(CLK), .RX_VALID(RX_VALID), .RX_WORD2(RX_WORD2),
        .RX_IS_DATA(RX_IS_DATA), .RX_IS_ACK(RX_IS_ACK), .RX_IS_BUSY(RX_IS_BUSY),
        .RX_FIRST_OF_EXCH(RX_FIRST_OF_EXCH)
    );

    // Free-running 100 MHz clock
    initial begin
        forever #5 CLK = ~CLK;
    end

    // Hang guard, well above the expected run
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, v};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        forever begin
            @(posedge CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) break;
        end
        chk("bresp", S_AXI_BRESP, RESP_OKAY);
        S_AXI_BREADY <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
        forever begin
            @(posedge CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) break;
        end
        {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
        S_AXI_RREADY <= 1'b0;
    endtask : rd

    // One header request; v = data,ack,end,newx,news,xfer,early,lclast,abt,fill
    task automatic tx(input logic [11:0] v);
        @(posedge CLK);
        {TX_IS_DATA, TX_IS_ACK, TX_END_SEQ, TX_NEW_EXCH, TX_NEW_SEQ, TX_XFER_INIT,
         TX_LAST_EARLY, TX_LC_LAST, TX_ABT_CODE, TX_FILL} <= v;
        TX_REQ <= 1'b1;
        @(posedge CLK);
        TX_REQ <= 1'b0;
        #1;
        chk("tx_valid", TX_VALID, 1);
    endtask : tx

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rd(REG_TXCTL);
        chk("txctl_rst", d, 0);
        rd(8'h10);
        chk("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(REG_TXCTL, 32'h1AD);
        rd(REG_TXCTL);
        chk("txctl", d, 32'h1AD);
        $display("test registers done");
        tx(12'h903);
        chk("fctl_first", TX_FCTL, 24'hA2101B);
        tx(12'hAC0);
        chk("first_seq", TX_FCTL[21], 0);
        chk("last_seq", TX_FCTL[20], 0);
        chk("end_seq", TX_FCTL[19], 1);
        chk("init_xfer", TX_FCTL[16], 1);
        wr(REG_TXCTL, 32'h3B7);
        tx(12'h8A0);
        chk("early_last", {TX_FCTL[22], TX_FCTL[20], TX_FCTL[19]}, 3'b110);
        chk("ack_rsv", TX_FCTL[13:12], 2'b11);
        tx(12'h800);
        chk("sticky_last", TX_FCTL[20], 1);
        tx(12'h618);
        chk("ack_close", {TX_FCTL[20:19], TX_FCTL[5:4]}, 4'b1110);
        tx(12'h41C);
        chk("ack_obs", TX_FCTL[5:4], 2'b00);
        rd(REG_TXFLD);
        chk("txfld", d, 32'hD20000);
        $display("test transmit done");
        peer.send(32'hA9101B, 4'h9);
        #1;
        chk("rx_fields", {RX_FV, RX_RESPONDER, RX_SRC_RECIP, RX_FIRST_SEQ, RX_END_SEQ,
            RX_INIT_XFER, RX_ACK_FORM, RX_ABT_VALID, RX_ABT_CODE, RX_REL_OFF, RX_FILL,
            RJT_REQ}, 16'h6EDE);
        peer.send(32'h130010, 4'h8);
        #1;
        chk("rx_ignored", {RX_FV, RX_INIT_XFER, RX_ABT_VALID, RJT_REQ, RX_LAST_SEQ,
            RX_PRIO_SEL}, 6'b100011);
        for (int i = 0; i < 4; i++) begin
            peer.send(rjw[i], rjq[i]);
            #1;
            chk("reject", {RJT_REQ, RJT_REASON}, {1'b1, rjr[i]});
        end
        rd(REG_RXSTAT);
        chk("rxstat", d, RJT_ABTOBS);
        rd(REG_RXFLD);
        chk("rxfld", d, 32'h400030);
        peer.send(32'h000000, 4'h2);
        #1;
        chk("busy_data", {RX_BUSY_DATA, RX_BUSY_ACK}, 2'b10);
        peer.send(32'h400000, 4'h2);
        #1;
        chk("busy_ack", {RX_BUSY_DATA, RX_BUSY_ACK}, 2'b01);
        // Lane 1 only: class and last-exchange bits clear, low byte must survive
        S_AXI_WSTRB <= 4'h2;
        wr(REG_TXCTL, 32'h0AD);
        rd(REG_TXCTL);
        chk("txctl_strb", d, 32'h0B7);
        peer.send(32'h002000, 4'h8);
        #1;
        chk("class3_quiet", RJT_REQ, 0);
        $display("test receive done");
        conclude();
    end
endmodule : frame_control_field_codec_tb
